//--- hdl/ebsl_corr_count.sv
`timescale 1ns/10ps
`default_nettype none

module ebsl_corr_count #(
    parameter int unsigned CNT_W = 15
) (
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    // Control
    input  wire logic             clear_i,
    input  wire logic             inc_i,
    // Count, top bit is sticky overflow
    output logic [CNT_W-1:0]      count_o
);

    logic [CNT_W-2:0] low_r;
    logic             ovf_r;
    logic [CNT_W-1:0] sum;

    assign sum     = {1'b0, low_r} + {{(CNT_W-1){1'b0}}, 1'b1};
    assign count_o = {ovf_r, low_r};

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            low_r <= ebsl_pkg::CORR_CNT_RST[CNT_W-2:0];
        end else if (clear_i && inc_i) begin
            // Event in the clearing cycle still counts
            low_r <= {{(CNT_W-2){1'b0}}, 1'b1};
        end else if (clear_i) begin
            low_r <= '0;
        end else if (inc_i) begin
            low_r <= sum[CNT_W-2:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ovf_r <= ebsl_pkg::CORR_CNT_RST[CNT_W-1];
        end else if (clear_i) begin
            ovf_r <= 1'b0;
        end else if (inc_i && sum[CNT_W-1]) begin
            ovf_r <= 1'b1;
        end
    end

endmodule : ebsl_corr_count

`default_nettype wire

//--- hdl/ebsl_error_bank.sv
`timescale 1ns/10ps
`default_nettype none

module ebsl_error_bank #(
    parameter int unsigned CNT_W = ebsl_pkg::CORR_CNT_W
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Capability bits from the global capability register
    input  wire logic        cap_corr_count_i,
    input  wire logic        cap_threshold_i,
    input  wire logic        cap_recovery_i,
    // Error posting from hardware units
    input  wire logic        ev_post_i,
    input  wire logic [15:0] ev_mca_code_i,
    input  wire logic [15:0] ev_model_code_i,
    input  wire logic [24:0] ev_info_i,
    input  wire logic        ev_monitored_i,
    input  wire logic [1:0]  ev_colour_i,
    input  wire logic        ev_signal_i,
    input  wire logic        ev_action_required_i,
    input  wire logic        ev_context_corrupt_i,
    input  wire logic        ev_address_log_ok_i,
    input  wire logic        ev_extra_info_ok_i,
    input  wire logic        ev_error_enable_bit_i,
    input  wire logic        ev_not_corrected_flag_i,
    // Register read and write port
    input  wire logic        reg_rd_i,
    input  wire logic        reg_wr_i,
    input  wire logic [63:0] reg_wdata_i,
    output logic [63:0]      reg_rdata_o,
    output logic             reg_rd_valid_o,
    output logic             gp_fault_o,
    // Status
    output logic             log_occupied_o,
    output logic             context_corrupt_o
);

    logic [63:0]      entry_r;
    logic [63:0]      entry_nxt;
    logic [63:0]      new_entry;
    logic [63:0]      rdata_r;
    logic             rd_valid_r;
    logic             fault_r;
    logic             clr_req;
    logic             held_valid;
    logic             overwrite;
    logic [1:0]       new_colour;
    logic [1:0]       held_colour;
    logic [CNT_W-1:0] corr_cnt;

    function automatic logic [63:0] ebsl_compose(input logic [63:0] entry,
                                                 input logic [CNT_W-1:0] cnt,
                                                 input logic cnt_on);
        ebsl_compose = entry;
        if (cnt_on) begin
            ebsl_compose[ebsl_pkg::CORR_OVF_BIT:ebsl_pkg::CORR_CNT_LSB] = cnt;
        end
    endfunction : ebsl_compose

    assign clr_req = reg_wr_i && (reg_wdata_i == ebsl_pkg::STATUS_RST);

    // Clear and post in one cycle: the post wins
    assign held_valid = entry_r[ebsl_pkg::OCCUPIED_BIT] && !clr_req;

    assign new_colour = ev_monitored_i ? ev_colour_i : ebsl_pkg::COLOUR_NONE;

    // Without threshold capability there is no colour to rank
    assign held_colour = cap_threshold_i ?
                         entry_r[ebsl_pkg::COLOUR_LSB +: ebsl_pkg::COLOUR_W] :
                         ebsl_pkg::COLOUR_NONE;

    ebsl_pick u_pick (
        .held_valid_i   (held_valid),
        .held_enabled_i (entry_r[ebsl_pkg::ENABLED_BIT]),
        .held_uncorr_i  (entry_r[ebsl_pkg::NOT_CORR_BIT]),
        .held_colour_i  (held_colour),
        .new_enabled_i  (ev_error_enable_bit_i),
        .new_uncorr_i   (ev_not_corrected_flag_i),
        .new_colour_i   (cap_threshold_i ? new_colour : ebsl_pkg::COLOUR_NONE),
        .overwrite_o    (overwrite)
    );

    ebsl_corr_count #(
        .CNT_W (CNT_W)
    ) u_count (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .clear_i   (clr_req),
        .inc_i     (ev_post_i && !ev_not_corrected_flag_i && cap_corr_count_i),
        .count_o   (corr_cnt)
    );

    // Build the word an arriving event would leave
    always_comb begin
        new_entry = ebsl_pkg::STATUS_RST;
        new_entry[ebsl_pkg::MCA_CODE_LSB +: ebsl_pkg::MCA_CODE_W] = ev_mca_code_i;
        new_entry[ebsl_pkg::MODEL_CODE_LSB +: ebsl_pkg::MODEL_CODE_W] = ev_model_code_i;
        new_entry[ebsl_pkg::INFO_LSB +: ebsl_pkg::INFO_W] = ev_info_i;
        if (cap_threshold_i) begin
            new_entry[ebsl_pkg::COLOUR_LSB +: ebsl_pkg::COLOUR_W] = new_colour;
            new_entry[ebsl_pkg::ACTION_REQ_BIT] = cap_recovery_i && ev_action_required_i;
            new_entry[ebsl_pkg::SIGNAL_BIT]     = cap_recovery_i && ev_signal_i;
        end
        new_entry[ebsl_pkg::CONTEXT_BIT]  = ev_context_corrupt_i;
        new_entry[ebsl_pkg::ADDR_OK_BIT]  = ev_address_log_ok_i;
        new_entry[ebsl_pkg::EXTRA_OK_BIT] = ev_extra_info_ok_i;
        new_entry[ebsl_pkg::ENABLED_BIT]  = ev_error_enable_bit_i;
        new_entry[ebsl_pkg::NOT_CORR_BIT] = ev_not_corrected_flag_i;
        new_entry[ebsl_pkg::OCCUPIED_BIT] = 1'b1;
    end

    // Next entry: clear, then replace or retain
    always_comb begin
        entry_nxt = clr_req ? ebsl_pkg::STATUS_RST : entry_r;
        if (ev_post_i) begin
            if (overwrite) begin
                entry_nxt = new_entry;
            end
            if (held_valid) begin
                entry_nxt[ebsl_pkg::OVERFLOW_BIT] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            entry_r <= ebsl_pkg::STATUS_RST;
        end else begin
            entry_r <= entry_nxt;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rdata_r    <= ebsl_pkg::STATUS_RST;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= reg_rd_i;
            if (reg_rd_i) begin
                rdata_r <= ebsl_compose(entry_r, corr_cnt, cap_corr_count_i);
            end
        end
    end

    // fault on any one bit written
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= reg_wr_i && (reg_wdata_i != ebsl_pkg::STATUS_RST);
        end
    end

    assign reg_rdata_o       = rdata_r;
    assign reg_rd_valid_o    = rd_valid_r;
    assign gp_fault_o        = fault_r;
    assign log_occupied_o    = entry_r[ebsl_pkg::OCCUPIED_BIT];
    assign context_corrupt_o = entry_r[ebsl_pkg::CONTEXT_BIT];

    chk_nonzero_write_fault: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (reg_wr_i && reg_wdata_i != 64'h0) |=> gp_fault_o)
        else $error("nonzero write did not fault");

    chk_fault_keeps_log: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (reg_wr_i && reg_wdata_i != 64'h0 && !ev_post_i) |=> $stable(entry_r))
        else $error("faulting write changed the log");

    chk_zero_write_clear: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (reg_wr_i && reg_wdata_i == 64'h0 && !ev_post_i) |=> !log_occupied_o && !entry_r[62])
        else $error("zero write did not clear");

    chk_post_sets_valid: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        ev_post_i |=> log_occupied_o)
        else $error("post left log empty");

    chk_first_code_logged: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && !log_occupied_o) |=>
            entry_r[15:0] == $past(ev_mca_code_i) && entry_r[31:16] == $past(ev_model_code_i))
        else $error("error codes not logged");

    chk_collision_overflow: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && log_occupied_o && !clr_req) |=> entry_r[62] ##1 (entry_r[62] || $past(clr_req)))
        else $error("collision did not set overflow");

    chk_uncorr_retained: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && log_occupied_o && !clr_req && entry_r[61]
            && entry_r[60] == ev_error_enable_bit_i) |=> $stable(entry_r[61:0]) && entry_r[62])
        else $error("uncorrected first entry lost");

    chk_yellow_kept: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && log_occupied_o && !clr_req && cap_threshold_i && !entry_r[61]
            && entry_r[54:53] == 2'h2 && !ev_not_corrected_flag_i
            && entry_r[60] == ev_error_enable_bit_i) |=> entry_r[31:0] == $past(entry_r[31:0]))
        else $error("yellow entry displaced by corrected event");

    chk_count_step: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && !ev_not_corrected_flag_i && cap_corr_count_i && !clr_req
            && corr_cnt[13:0] != 14'h3fff) |=> corr_cnt[13:0] == $past(corr_cnt[13:0]) + 14'h1)
        else $error("corrected count did not step");

    chk_count_sticky: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (corr_cnt[14] && !clr_req) |=> corr_cnt[14])
        else $error("count overflow bit dropped");

    chk_unmonitored_colour: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && !log_occupied_o && cap_threshold_i && !ev_monitored_i) |=>
            entry_r[54:53] == 2'h0)
        else $error("unmonitored event posted a colour");

    chk_read_counter: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (reg_rd_i && cap_corr_count_i) |=> reg_rd_valid_o && reg_rdata_o[52:38] == $past(corr_cnt))
        else $error("read did not show counter");

    chk_info_logged: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && !log_occupied_o) |=>
            entry_r[37:32] == $past(ev_info_i[5:0]))
        else $error("implementation information not logged");

    chk_event_flags: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && !log_occupied_o) |=>
            entry_r[61:57] == $past({ev_not_corrected_flag_i, ev_error_enable_bit_i,
                                     ev_extra_info_ok_i, ev_address_log_ok_i,
                                     ev_context_corrupt_i}))
        else $error("event flags not logged");

    chk_reserved_zero: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && !log_occupied_o && cap_threshold_i && !cap_recovery_i) |=>
            entry_r[56:55] == 2'h0)
        else $error("reserved bits not zero");

    chk_recovery_flags: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && !log_occupied_o && cap_threshold_i && cap_recovery_i) |=>
            entry_r[56:55] == $past({ev_signal_i, ev_action_required_i}))
        else $error("recovery flags not logged");

    chk_enabled_wins: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && log_occupied_o && !clr_req && !entry_r[60] && ev_error_enable_bit_i)
            |=> entry_r[60] && entry_r[15:0] == $past(ev_mca_code_i))
        else $error("enabled event did not replace disabled entry");

    chk_green_replaced: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && log_occupied_o && !clr_req && cap_threshold_i && !entry_r[61]
            && entry_r[54:53] != 2'h2 && !ev_not_corrected_flag_i
            && entry_r[60] == ev_error_enable_bit_i) |=>
            entry_r[31:0] == $past({ev_model_code_i, ev_mca_code_i}))
        else $error("later corrected event did not replace green entry");

    chk_overwrite_whole: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (ev_post_i && overwrite) |=> entry_r[61:0] == $past(new_entry[61:0]))
        else $error("overwrite did not take the whole word");

endmodule : ebsl_error_bank

`default_nettype wire

//--- hdl/ebsl_pick.sv
`timescale 1ns/10ps
`default_nettype none

module ebsl_pick (
    // Entry already held
    input  wire logic       held_valid_i,
    input  wire logic       held_enabled_i,
    input  wire logic       held_uncorr_i,
    input  wire logic [1:0] held_colour_i,
    // Arriving event
    input  wire logic       new_enabled_i,
    input  wire logic       new_uncorr_i,
    input  wire logic [1:0] new_colour_i,
    // Decision
    output logic            overwrite_o
);

    function automatic logic ebsl_is_yellow(input logic [1:0] colour);
        ebsl_is_yellow = (colour == ebsl_pkg::COLOUR_YELLOW);
    endfunction : ebsl_is_yellow

    // yellow over green, later green kept
    always_comb begin
        if (!held_valid_i) begin
            overwrite_o = 1'b1;
        end else if (held_enabled_i != new_enabled_i) begin
            overwrite_o = new_enabled_i;
        end else if (held_uncorr_i) begin
            overwrite_o = 1'b0;
        end else if (new_uncorr_i) begin
            overwrite_o = 1'b1;
        end else if (ebsl_is_yellow(held_colour_i)) begin
            // Two yellows keep the first; saves a write
            overwrite_o = 1'b0;
        end else begin
            overwrite_o = 1'b1;
        end
    end

endmodule : ebsl_pick

`default_nettype wire

//--- hdl/ebsl_pkg.sv
package ebsl_pkg;

    // Field positions of the bank error status word
    localparam int unsigned STATUS_W       = 64;
    localparam int unsigned MCA_CODE_LSB   = 0;
    localparam int unsigned MCA_CODE_W     = 16;
    localparam int unsigned MODEL_CODE_LSB = 16;
    localparam int unsigned MODEL_CODE_W   = 16;
    localparam int unsigned INFO_LSB       = 32;
    localparam int unsigned INFO_W         = 25;
    localparam int unsigned OTHER_LO_LSB   = 32;
    localparam int unsigned OTHER_LO_W     = 6;
    localparam int unsigned CORR_CNT_LSB   = 38;
    localparam int unsigned CORR_CNT_W     = 15;
    localparam int unsigned CORR_OVF_BIT   = 52;
    localparam int unsigned COLOUR_LSB     = 53;
    localparam int unsigned COLOUR_W       = 2;
    localparam int unsigned ACTION_REQ_BIT = 55;
    localparam int unsigned SIGNAL_BIT     = 56;
    localparam int unsigned CONTEXT_BIT    = 57;
    localparam int unsigned ADDR_OK_BIT    = 58;
    localparam int unsigned EXTRA_OK_BIT   = 59;
    localparam int unsigned ENABLED_BIT    = 60;
    localparam int unsigned NOT_CORR_BIT   = 61;
    localparam int unsigned OVERFLOW_BIT   = 62;
    localparam int unsigned OCCUPIED_BIT   = 63;

    // Reset and cleared value
    localparam logic [63:0] STATUS_RST     = 64'h0000_0000_0000_0000;
    localparam logic [14:0] CORR_CNT_RST   = 15'h0000;

    // Structure health colours
    localparam logic [1:0]  COLOUR_NONE    = 2'h0;
    localparam logic [1:0]  COLOUR_GREEN   = 2'h1;
    localparam logic [1:0]  COLOUR_YELLOW  = 2'h2;

endpackage : ebsl_pkg

//--- tb/ebsl_unit_model.sv
`timescale 1ns/10ps
`default_nettype none

module ebsl_unit_model (
    // Clock
    input  wire logic        sys_clk_i,
    // Event posting, fields packed
    output logic             ev_post_o,
    output logic [66:0]      ev_fields_o
);
    initial begin
        ev_post_o   = 1'b0;
        ev_fields_o = 67'h0;
    end

    // flags travel with event
    // Holds the strobe, so posts may run back to back
    task automatic post(input logic [66:0] f);
        ev_post_o   <= 1'b1;
        ev_fields_o <= f;
        @(posedge sys_clk_i);
    endtask : post

    // Fields mean nothing between posts
    task automatic idle();
        ev_post_o   <= 1'b0;
        ev_fields_o <= ~ev_fields_o;
        @(posedge sys_clk_i);
    endtask : idle
endmodule : ebsl_unit_model

`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cc = 1'b0;
    logic        ct = 1'b0;
    logic        cr = 1'b0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [63:0] wd = 64'h0;
    logic [63:0] rdata;
    logic        rdv;
    logic        gpf;
    logic        occ;
    logic        context_corrupt;
    logic        post;
    logic [66:0] f;
    logic [63:0] exp_w = 64'h0;
    logic [14:0] exp_cnt = 15'h0;
    int          errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;

    ebsl_unit_model unit (.sys_clk_i(sys_clk_i), .ev_post_o(post), .ev_fields_o(f));

    ebsl_error_bank dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .cap_corr_count_i(cc), .cap_threshold_i(ct), .cap_recovery_i(cr),
        .ev_post_i(post), .ev_mca_code_i(f[66:51]), .ev_model_code_i(f[50:35]),
        .ev_info_i(f[34:10]), .ev_monitored_i(f[9]), .ev_colour_i(f[8:7]),
        .ev_signal_i(f[6]), .ev_action_required_i(f[5]),
        .ev_context_corrupt_i(f[4]), .ev_address_log_ok_i(f[3]),
        .ev_extra_info_ok_i(f[2]), .ev_error_enable_bit_i(f[1]),
        .ev_not_corrected_flag_i(f[0]),
        .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rdata),
        .reg_rd_valid_o(rdv), .gp_fault_o(gpf),
        .log_occupied_o(occ), .context_corrupt_o(context_corrupt)
    );

    task automatic stop_test();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    // Cut a hang short
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errors = errors + 1;
            stop_test();
        end
    end

    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        cmp_count = cmp_count + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    function automatic logic [63:0] word_of(input logic [66:0] v);
        logic [63:0] w;
        w = {1'b1, 1'b0, v[0], v[1], v[2], v[3], v[4], v[34:10], v[50:35], v[66:51]};
        if (ct) begin
            w[54:53] = v[9] ? v[8:7] : 2'h0;
            w[56:55] = cr ? v[6:5] : 2'h0;
        end
        return w;
    endfunction : word_of

    function automatic logic [1:0] col(input logic [63:0] w);
        return ct ? w[54:53] : 2'h0;
    endfunction : col

    // Reference for collision choice and counting
    task automatic apply(input logic [66:0] v);
        logic [63:0] n;
        logic        ow;
        n = word_of(v);
        if (!exp_w[63]) ow = 1'b1;
        else if (exp_w[60] != n[60]) ow = n[60];
        else if (exp_w[61]) ow = 1'b0;
        else if (n[61]) ow = 1'b1;
        else ow = (col(exp_w) != 2'h2);
        if (exp_w[63]) n[62] = 1'b1;
        exp_w = ow ? n : {exp_w[63], n[62], exp_w[61:0]};
        if (cc && !v[0]) begin
            if (exp_cnt[13:0] == 14'h3fff) exp_cnt[14] = 1'b1;
            exp_cnt[13:0] = exp_cnt[13:0] + 14'h1;
        end
    endtask : apply

    task automatic send(input logic [66:0] v);
        apply(v);
        unit.post(v);
    endtask : send

    function automatic logic [66:0] rnd_ev();
        logic [66:0] v;
        v = 67'({$urandom, $urandom, $urandom});
        if (v[8:7] == 2'h3) v[8:7] = 2'h2;
        return v;
    endfunction : rnd_ev

    task automatic rd_chk();
        logic [63:0] e;
        e = exp_w;
        if (cc) e[52:38] = exp_cnt;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1;
        chk(64'(rdv), 64'h1);
        chk(rdata, e);
        chk(64'({occ, context_corrupt}), 64'({e[63], e[57]}));
        @(posedge sys_clk_i);
    endtask : rd_chk

    task automatic wr_chk(input logic [63:0] d);
        wr <= 1'b1;
        wd <= d;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        #1;
        chk(64'(gpf), 64'(d != 64'h0));
        if (d == 64'h0) begin
            exp_w = 64'h0;
            exp_cnt = 15'h0;
        end
        @(posedge sys_clk_i);
    endtask : wr_chk

    // Clear and post together: the post wins, no overflow
    task automatic clr_post(input logic [66:0] v);
        exp_w = 64'h0;
        exp_cnt = 15'h0;
        wr <= 1'b1;
        wd <= 64'h0;
        send(v);
        wr <= 1'b0;
        unit.idle();
        rd_chk();
    endtask : clr_post

    initial begin
        logic [66:0] v;
        void'($urandom(32'h60401ef2));
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        rd_chk();
        // Every capability mix, recovery also without threshold
        for (int k = 0; k < 8; k++) begin
            {cc, ct, cr} <= 3'(k);
            wr_chk(64'h0);
            repeat (40) begin
                repeat (1 + $urandom % 3) send(rnd_ev());
                unit.idle();
                rd_chk();
                if ($urandom % 3 == 0) wr_chk(64'h1 << ($urandom % 64));
                if ($urandom % 5 == 0) wr_chk(64'h0);
                if ($urandom % 7 == 0) clr_post(rnd_ev());
            end
        end
        // Wrap the low count so the sticky top bit sets
        {cc, ct, cr} <= 3'h7;
        wr_chk(64'h0);
        repeat (16386) begin
            v = rnd_ev();
            v[0] = 1'b0;
            send(v);
        end
        unit.idle();
        rd_chk();
        stop_test();
    end
endmodule : testbench

`default_nettype wire
